/* logic/ccp_power_path_ctrl.v */
// Charge-cycle and power-path control with APB register file
`timescale 1ns/10ps
`include "ccp_consts.vh"

module ccp_power_path_ctrl #(
   parameter [31:0] BOOST_DLY_CYCLES = `CCP_BOOST_DLY_MS * 1000000 / `CCP_CLK_NS,
   parameter [31:0] BLINK_CYCLES     = `CCP_BLINK_MS * 1000000 / `CCP_CLK_NS,
   parameter [63:0] HOUR_CYCLES      = `CCP_HOUR_S * 64'd1000000000 / `CCP_CLK_NS
) (
   // APB slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Input source side
   input  wire        external_current_clamp_pin_set_done,
   input  wire        vin_limit_done,
   input  wire [7:0]  auto_vin_limit_code,
   input  wire [2:0]  source_type_code,
   input  wire        src_high_power_det,
   input  wire        optimizer_done,
   input  wire [5:0]  optimizer_code,
   input  wire [5:0]  external_current_clamp_pin,
   input  wire        sys_below_2v2,
   input  wire        input_over_current,
   input  wire        input_under_voltage,
   input  wire        thermal_reg,
   // Battery and system side
   input  wire        bat_below_sysmin,
   input  wire        sys_at_min_reg,
   input  wire        sys_below_bat,
   input  wire        bat_below_depletion,
   input  wire        bat_below_2v,
   input  wire        bat_below_3v,
   input  wire        chg_current_below_term,
   input  wire        bat_above_recharge,
   input  wire        thermistor_fault,
   input  wire        charge_enable_n,
   // Boost qualification
   input  wire        bat_above_lowv,
   input  wire        vin_below_bat_sleep,
   input  wire        boost_request_pin,
   input  wire        thermistor_boost_ok,
   // Control outputs
   output reg         host_event,
   output reg         converter_enable,
   output reg         battery_switch,
   output reg  [5:0]  input_current_limit,
   output reg         optimizer_run,
   output reg         pulse_skip_light_load,
   output reg         boost_enable,
   output reg  [1:0]  charge_current_mode,
   output reg         charging_active,
   output reg         timer_half_rate,
   output wire        boost_switch_rate_select,
   output wire [2:0]  boost_current_limit,
   output wire [3:0]  boost_output_voltage,
   output wire        recharge_offset_select,
   output wire [31:0] charge_settings,
   // Status pin
   output reg         status_pin_out,
   output reg         status_pin_oe
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [3:0] ST_IDLE  = 4'b0001;
   localparam [3:0] ST_CHG   = 4'b0010;
   localparam [3:0] ST_DONE  = 4'b0100;
   localparam [3:0] ST_FAULT = 4'b1000;

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   reg [9:0]  ctrl_reg;
   reg [7:0]  vlim_reg;
   reg [15:0] cur_reg;
   reg [31:0] chg_reg;
   reg [5:0]  opt_result_reg;
   reg [31:0] prdata_reg;
   reg        pready_reg;
   reg        pslverr_reg;
   reg [3:0]  state_reg;
   reg [3:0]  state_next;
   reg        supplement_reg;
   reg        vflag_reg;
   reg        iflag_reg;
   reg        minsys_flag_reg;
   reg [1:0]  fault_reg;
   reg [1:0]  phase_reg;
   reg [2:0]  src_status_reg;
   reg        blink_reg;
   reg [31:0] blink_cnt_reg;
   reg [31:0] rd_data;
   reg        rd_hit;
   reg [5:0]  external_current_clamp_pin_next;
   reg [5:0]  base_lim;
   reg [63:0] safety_limit;

   wire       access  = psel && penable && !pready_reg;
   wire       wr_fire = psel && penable && pready_reg && pwrite && !pslverr_reg;
   wire       wr_ctrl = wr_fire && (paddr == `CCP_OFF_CTRL);
   wire       wr_vlim = wr_fire && (paddr == `CCP_OFF_VLIM);
   wire       wr_cur  = wr_fire && (paddr == `CCP_OFF_CUR);
   wire       wr_chg  = wr_fire && (paddr == `CCP_OFF_CHG);

   wire       abs_mode  = ctrl_reg[`CCP_CTRL_ABS_VLIM];
   wire       opt_en    = ctrl_reg[`CCP_CTRL_OPT_EN];
   wire       boost_cfg = ctrl_reg[`CCP_CTRL_BOOST_CFG];
   wire       bsw_dis   = ctrl_reg[`CCP_CTRL_BSW_DIS];
   wire       chg_en    = ctrl_reg[`CCP_CTRL_CHG_CFG] && !charge_enable_n;
   wire       overload  = input_over_current || input_under_voltage;
   wire       slow_tmr  = overload || thermal_reg;
   wire [6:0] fast_cur  = chg_reg[6:0];
   wire [1:0] tmr_sel   = chg_reg[29:28];

   wire       start_ok  = converter_enable && chg_en && (fast_cur != 7'h00) &&
                          !thermistor_fault && !bsw_dis;
   wire       term_ok   = chg_current_below_term && bat_above_recharge && !slow_tmr;
   wire       boost_ok  = bat_above_lowv && vin_below_bat_sleep && boost_request_pin &&
                          boost_cfg && thermistor_boost_ok;
   wire       boost_dly_exp;
   wire       safety_exp;
   wire       vin_evt   = (vin_limit_done && !abs_mode) || (wr_vlim && abs_mode);
   wire       done_evt  = state_reg[1] && (state_next == ST_DONE);
   wire       fault_evt = state_reg[1] && (state_next == ST_FAULT);

   assign prdata                   = prdata_reg;
   assign pready                   = pready_reg;
   assign pslverr                  = pslverr_reg;
   assign boost_switch_rate_select = ctrl_reg[`CCP_CTRL_BOOST_RATE];
   assign boost_current_limit      = cur_reg[10:8];
   assign boost_output_voltage     = cur_reg[15:12];
   assign recharge_offset_select   = ctrl_reg[`CCP_CTRL_RECHG_OFS];
   assign charge_settings          = chg_reg;

   // ----------------------------------------
   // Timers
   // ----------------------------------------
   always @*
   begin
      case (tmr_sel)
         2'h0:    safety_limit = 64'd5 * HOUR_CYCLES;
         2'h1:    safety_limit = 64'd8 * HOUR_CYCLES;
         2'h2:    safety_limit = 64'd12 * HOUR_CYCLES;
         default: safety_limit = 64'd20 * HOUR_CYCLES;
      endcase
   end

   ccp_timer #(.WIDTH(32)) u_boost_dly (
      .clk       (pclk),
      .rst_n     (presetn),
      .run       (boost_ok),
      .half_rate (1'b0),
      .limit     (BOOST_DLY_CYCLES),
      .expired   (boost_dly_exp)
   );

   ccp_timer #(.WIDTH(64)) u_safety (
      .clk       (pclk),
      .rst_n     (presetn),
      .run       (state_reg[1]),
      .half_rate (slow_tmr),
      .limit     (safety_limit),
      .expired   (safety_exp)
   );

   // ----------------------------------------
   // APB read decode
   // ----------------------------------------
   always @*
   begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (paddr)
         `CCP_OFF_CTRL:   rd_data = {22'h00_0000, ctrl_reg};
         `CCP_OFF_VLIM:   rd_data = {24'h00_0000, vlim_reg};
         `CCP_OFF_CUR:    rd_data = {16'h0000, cur_reg};
         `CCP_OFF_CHG:    rd_data = chg_reg;
         `CCP_OFF_STATUS: rd_data = {19'h0_0000, boost_enable, pulse_skip_light_load, supplement_reg,
                                     fault_reg, iflag_reg, vflag_reg, minsys_flag_reg, phase_reg,
                                     src_status_reg};
         `CCP_OFF_OPT:    rd_data = {26'h000_0000, opt_result_reg};
         default:         rd_hit  = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end
      else if (access)
      begin
         pready_reg  <= 1'b1;
         pslverr_reg <= !rd_hit;
         prdata_reg  <= (pwrite || !rd_hit) ? 32'h0000_0000 : rd_data;
      end
      else
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= `CCP_CTRL_RST;
         vlim_reg <= `CCP_VLIM_RST;
         cur_reg  <= `CCP_CUR_RST;
         chg_reg  <= `CCP_CHG_RST;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_reg <= pwdata[9:0];
            if (boost_cfg)
               ctrl_reg[`CCP_CTRL_BOOST_RATE] <= ctrl_reg[`CCP_CTRL_BOOST_RATE];
            if (!pwdata[`CCP_CTRL_OPT_FORCE])
               ctrl_reg[`CCP_CTRL_OPT_FORCE] <= ctrl_reg[`CCP_CTRL_OPT_FORCE] && !optimizer_done;
         end
         else if (optimizer_done)
            ctrl_reg[`CCP_CTRL_OPT_FORCE] <= 1'b0;
         if (wr_vlim && abs_mode)
            vlim_reg <= pwdata[7:0];
         else if (vin_limit_done && !abs_mode)
            vlim_reg <= auto_vin_limit_code;
         if (wr_cur)
            cur_reg <= pwdata[15:0];
         if (wr_chg)
            chg_reg <= pwdata;
      end
   end

   // ----------------------------------------
   // Input current optimizer and limit
   // ----------------------------------------
   always @*
   begin
      base_lim = opt_en ? opt_result_reg : cur_reg[5:0];
      if (ctrl_reg[`CCP_CTRL_CLAMP_EN] && (external_current_clamp_pin < base_lim))
         base_lim = external_current_clamp_pin;
      if (sys_below_2v2)
         external_current_clamp_pin_next = (cur_reg[5:0] < `CCP_SOFT_EXTERNAL_CURRENT_CLAMP_PIN) ? cur_reg[5:0] : `CCP_SOFT_EXTERNAL_CURRENT_CLAMP_PIN;
      else
         external_current_clamp_pin_next = base_lim;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         optimizer_run       <= 1'b0;
         opt_result_reg      <= `CCP_OPT_RST;
         input_current_limit <= `CCP_SOFT_EXTERNAL_CURRENT_CLAMP_PIN;
         converter_enable    <= 1'b0;
      end
      else
      begin
         if ((opt_en && src_high_power_det) || (wr_ctrl && pwdata[`CCP_CTRL_OPT_FORCE]))
            optimizer_run <= 1'b1;
         else if (optimizer_done)
            optimizer_run <= 1'b0;
         if (optimizer_done)
            opt_result_reg <= optimizer_code;
         input_current_limit <= external_current_clamp_pin_next;
         if (external_current_clamp_pin_set_done)
            converter_enable <= 1'b1;
      end
   end

   // ----------------------------------------
   // Power path status
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         supplement_reg        <= 1'b0;
         vflag_reg             <= 1'b0;
         iflag_reg             <= 1'b0;
         minsys_flag_reg       <= 1'b0;
         battery_switch        <= 1'b0;
         pulse_skip_light_load <= 1'b0;
         boost_enable          <= 1'b0;
         src_status_reg        <= 3'h0;
         timer_half_rate       <= 1'b0;
      end
      else
      begin
         if (sys_below_bat)
            supplement_reg <= 1'b1;
         else if (bat_below_depletion)
            supplement_reg <= 1'b0;
         vflag_reg       <= input_under_voltage;
         iflag_reg       <= input_over_current;
         minsys_flag_reg <= sys_at_min_reg;
         battery_switch  <= supplement_reg ||
                            (converter_enable && chg_en && !bsw_dis && !state_reg[2]);
         pulse_skip_light_load <= bat_below_sysmin || !chg_en;
         boost_enable    <= boost_ok && boost_dly_exp;
         src_status_reg  <= (boost_ok && boost_dly_exp) ? `CCP_SRC_BOOST : source_type_code;
         timer_half_rate <= slow_tmr && state_reg[1];
      end
   end

   // ----------------------------------------
   // Charge cycle
   // ----------------------------------------
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (start_ok)
               state_next = ST_CHG;
         ST_CHG:
            if (!chg_en)
               state_next = ST_IDLE;
            else if (safety_exp)
               state_next = ST_FAULT;
            else if (term_ok)
               state_next = ST_DONE;
         ST_DONE:
            if (!chg_en)
               state_next = ST_IDLE;
            else if (!bat_above_recharge && start_ok)
               state_next = ST_CHG;
         ST_FAULT:
            if (!chg_en)
               state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg           <= ST_IDLE;
         phase_reg           <= `CCP_PH_OFF;
         fault_reg           <= `CCP_FAULT_NONE;
         charge_current_mode <= `CCP_CUR_SHORT;
         charging_active     <= 1'b0;
         host_event          <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         case (state_next)
            ST_CHG:  phase_reg <= bat_below_3v ? `CCP_PH_PRE : `CCP_PH_FAST;
            ST_DONE: phase_reg <= `CCP_PH_DONE;
            default: phase_reg <= `CCP_PH_OFF;
         endcase
         if (bat_below_2v)
            charge_current_mode <= `CCP_CUR_SHORT;
         else if (bat_below_3v)
            charge_current_mode <= `CCP_CUR_PRE;
         else
            charge_current_mode <= `CCP_CUR_FAST;
         charging_active <= (state_next == ST_CHG) && !thermistor_fault;
         if (fault_evt)
            fault_reg <= `CCP_FAULT_TIMER;
         else if (!chg_en)
            fault_reg <= `CCP_FAULT_NONE;
         host_event <= vin_evt || done_evt || fault_evt;
      end
   end

   // ----------------------------------------
   // Status pin
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         blink_cnt_reg <= 32'h0000_0000;
         blink_reg     <= 1'b0;
      end
      else if (!state_reg[3])
      begin
         blink_cnt_reg <= 32'h0000_0000;
         blink_reg     <= 1'b0;
      end
      else if (blink_cnt_reg >= BLINK_CYCLES - 32'h0000_0001)
      begin
         blink_cnt_reg <= 32'h0000_0000;
         blink_reg     <= ~blink_reg;
      end
      else
         blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_pin_out <= 1'b1;
         status_pin_oe  <= 1'b0;
      end
      else
      begin
         status_pin_oe <= !ctrl_reg[`CCP_CTRL_STPIN_DIS];
         if (state_reg[3])
            status_pin_out <= blink_reg;
         else
            status_pin_out <= !state_reg[1];
      end
   end

endmodule // ccp_power_path_ctrl

/* logic/ccp_consts.vh */
// Register map, field layout, reset values and timing figures of the charge/power-path controller
`ifndef CCP_CONSTS_VH
`define CCP_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CCP_OFF_CTRL      8'h00
`define CCP_OFF_VLIM      8'h04
`define CCP_OFF_CUR       8'h08
`define CCP_OFF_CHG       8'h0C
`define CCP_OFF_STATUS    8'h10
`define CCP_OFF_OPT       8'h14

// ----------------------------------------
// Control register bits
// ----------------------------------------
`define CCP_CTRL_ABS_VLIM   0
`define CCP_CTRL_OPT_EN     1
`define CCP_CTRL_OPT_FORCE  2
`define CCP_CTRL_CLAMP_EN   3
`define CCP_CTRL_BOOST_CFG  4
`define CCP_CTRL_BOOST_RATE 5
`define CCP_CTRL_CHG_CFG    6
`define CCP_CTRL_BSW_DIS    7
`define CCP_CTRL_RECHG_OFS  8
`define CCP_CTRL_STPIN_DIS  9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCP_CTRL_RST      10'h04A
`define CCP_VLIM_RST      8'h00
`define CCP_CUR_RST       16'h7008
`define CCP_CHG_RST       32'h2D42_1720
`define CCP_OPT_RST       6'h3F

// ----------------------------------------
// Codes
// ----------------------------------------
`define CCP_SOFT_EXTERNAL_CURRENT_CLAMP_PIN     6'h02
`define CCP_SRC_BOOST     3'h7
`define CCP_PH_OFF        2'h0
`define CCP_PH_PRE        2'h1
`define CCP_PH_FAST       2'h2
`define CCP_PH_DONE       2'h3
`define CCP_FAULT_NONE    2'h0
`define CCP_FAULT_TIMER   2'h3
`define CCP_CUR_SHORT     2'h0
`define CCP_CUR_PRE       2'h1
`define CCP_CUR_FAST      2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define CCP_CLK_NS        10
`define CCP_BOOST_DLY_MS  30
`define CCP_BLINK_MS      500
`define CCP_HOUR_S        64'd3600

`endif

/* logic/ccp_timer.v */
// Run-gated cycle counter with optional half-rate counting
`timescale 1ns/10ps
module ccp_timer #(
   parameter WIDTH = 32
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // Control
   input  wire             run,
   input  wire             half_rate,
   input  wire [WIDTH-1:0] limit,
   // Result
   output wire             expired
);

   reg [WIDTH-1:0] count_reg;
   reg             phase_reg;
   reg             expired_reg;

   assign expired = expired_reg;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg   <= {WIDTH{1'b0}};
         phase_reg   <= 1'b0;
         expired_reg <= 1'b0;
      end
      else if (!run)
      begin
         count_reg   <= {WIDTH{1'b0}};
         phase_reg   <= 1'b0;
         expired_reg <= 1'b0;
      end
      else
      begin
         phase_reg <= ~phase_reg;
         if (count_reg >= limit)
            expired_reg <= 1'b1;
         else if (!half_rate || phase_reg)
            count_reg <= count_reg + 1'b1;
      end
   end

endmodule // ccp_timer

/* dv/ccp_props.sv */
// Port assertions for the charge/power-path controller
`timescale 1ns/10ps
module ccp_props (
   // Clock and reset
   input wire       pclk,
   input wire       presetn,
   // Watched inputs
   input wire       sys_below_2v2,
   input wire       bat_below_sysmin,
   input wire       sys_below_bat,
   input wire       boost_request_pin,
   input wire       charge_enable_n,
   // Watched outputs
   input wire [5:0] input_current_limit,
   input wire       pulse_skip_light_load,
   input wire       battery_switch,
   input wire       converter_enable,
   input wire       boost_enable,
   input wire       charging_active,
   input wire       status_pin_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_soft_cap: assert property (sys_below_2v2 |=> input_current_limit <= 6'h02)
      else $error("soft-start limit above cap");
   a_pskip_low: assert property (bat_below_sysmin |=> pulse_skip_light_load)
      else $error("pulse skip not selected");
   a_supp_on: assert property (sys_below_bat |-> ##2 battery_switch)
      else $error("supplement switch not on");
   a_conv_hold: assert property (converter_enable |=> converter_enable)
      else $error("converter enable dropped");
   a_boost_delay: assert property ($rose(boost_enable) |-> $past(boost_request_pin, 20))
      else $error("boost enabled before delay");
   a_boost_off: assert property (!boost_request_pin [*3] |-> !boost_enable)
      else $error("boost on without request pin");
   a_chg_off: assert property (charge_enable_n [*2] |-> !charging_active)
      else $error("charging while enable pin high");
   a_stat_low: assert property (charging_active [*2] |-> !status_pin_out)
      else $error("status pin high while charging");
endmodule // ccp_props

bind ccp_power_path_ctrl ccp_props ccp_props_inst (.pclk, .presetn, .sys_below_2v2, .bat_below_sysmin,
   .sys_below_bat, .boost_request_pin, .charge_enable_n, .input_current_limit, .pulse_skip_light_load,
   .battery_switch, .converter_enable, .boost_enable, .charging_active, .status_pin_out);

/* dv/ccp_host_model.sv */
// Host model issuing APB transfers to the controller
`timescale 1ns/10ps
module ccp_host_model (
   // APB master side
   input  wire        pclk,
   output reg         psel,
   output reg         penable,
   output reg         pwrite,
   output reg  [7:0]  paddr,
   output reg  [31:0] pwdata,
   input  wire [31:0] prdata,
   input  wire        pready,
   input  wire        pslverr
);
   initial {psel, penable, pwrite, paddr, pwdata} = 0;
   // Setup, access, hold until pready sampled high
   task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // ccp_host_model

/* dv/tb_top.sv */
// Self-checking bench for the charge/power-path controller
`timescale 1ns/10ps
`include "ccp_consts.vh"
module tb_top;
   reg pclk = 0, presetn = 0, lo = 0, external_current_clamp_pin_set_done = 0, vin_limit_done = 0, optimizer_done = 0;
   reg src_high_power_det = 0, bat_below_3v = 0, thermistor_fault = 0;
   reg sys_below_2v2 = 0, input_over_current = 0, input_under_voltage = 0, thermal_reg = 0;
   reg bat_below_sysmin = 0, sys_at_min_reg = 0, sys_below_bat = 0, bat_below_depletion = 0;
   reg chg_current_below_term = 0, bat_above_recharge = 0, charge_enable_n = 1, bat_above_lowv = 0;
   reg vin_below_bat_sleep = 0, boost_request_pin = 0, thermistor_boost_ok = 0, e;
   reg [7:0] auto_vin_limit_code = 0;
   reg [5:0] optimizer_code = 0, clamp = 6'h3F;
   reg [31:0] q;
   wire psel, penable, pwrite, pready, pslverr, host_event, battery_switch, boost_enable;
   wire charging_active, status_pin_out;
   wire [7:0] paddr;
   wire [31:0] pwdata, prdata;
   wire [5:0] input_current_limit;
   wire [2:0] bcl;
   wire [3:0] bov;
   wire [1:0] ccm;
   wire [31:0] cset;
   wire orun, thr, bsr, ros, oe;
   integer bad_count = 0, checks_done = 0;
   initial forever #5 pclk = ~pclk;
   ccp_host_model ccp_host_model_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   ccp_power_path_ctrl #(.BOOST_DLY_CYCLES(20), .BLINK_CYCLES(8), .HOUR_CYCLES(10)) ccp_power_path_ctrl_inst (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .external_current_clamp_pin_set_done, .vin_limit_done, .auto_vin_limit_code, .source_type_code(3'h3), .src_high_power_det,
      .optimizer_done, .optimizer_code, .external_current_clamp_pin(clamp), .sys_below_2v2, .input_over_current,
      .input_under_voltage, .thermal_reg, .bat_below_sysmin, .sys_at_min_reg, .sys_below_bat, .bat_below_depletion,
      .bat_below_2v(lo), .bat_below_3v, .chg_current_below_term, .bat_above_recharge, .thermistor_fault,
      .charge_enable_n, .bat_above_lowv, .vin_below_bat_sleep, .boost_request_pin, .thermistor_boost_ok,
      .host_event, .converter_enable(), .battery_switch, .input_current_limit, .optimizer_run(orun),
      .pulse_skip_light_load(), .boost_enable, .charge_current_mode(ccm), .charging_active, .timer_half_rate(thr),
      .boost_switch_rate_select(bsr), .boost_current_limit(bcl), .boost_output_voltage(bov),
      .recharge_offset_select(ros), .charge_settings(cset), .status_pin_out, .status_pin_oe(oe));
   task end_sim;
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input [31:0] g, input [31:0] x);
      checks_done = checks_done + 1;
      if (g !== x)
      begin
         bad_count = bad_count + 1;
         $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      ccp_host_model_inst.xfer(1'b1, a, d, q, e);
   endtask
   task rd(input [7:0] a);
      ccp_host_model_inst.xfer(1'b0, a, 32'h0, q, e);
   endtask
   task wait_n(input integer n);
      repeat (n) @(posedge pclk);
   endtask
   task t_reset;
      rd(`CCP_OFF_CTRL);
      chk(q, 32'h0000_004A);
      rd(`CCP_OFF_CHG);
      chk(q, 32'h2D42_1720);
      rd(`CCP_OFF_CUR);
      chk(q, 32'h0000_7008);
      chk({bov, 1'b0, bcl}, 32'h0000_0070);
      chk(cset, 32'h2D42_1720);
      chk(oe, 32'h0000_0001);
      rd(8'h18);
      chk({31'h0, e}, 32'h0000_0001);
   endtask
   task t_vlim;
      auto_vin_limit_code <= 8'h5A;
      vin_limit_done <= 1'b1;
      @(posedge pclk);
      vin_limit_done <= 1'b0;
      @(posedge pclk);
      chk({31'h0, host_event}, 32'h0000_0001);
      wr(`CCP_OFF_VLIM, 32'h0000_0033);
      rd(`CCP_OFF_VLIM);
      chk(q, 32'h0000_005A);
      wr(`CCP_OFF_CTRL, 32'h0000_004B);
      wr(`CCP_OFF_VLIM, 32'h0000_0033);
      rd(`CCP_OFF_VLIM);
      chk(q, 32'h0000_0033);
   endtask
   task t_limit;
      sys_below_2v2 <= 1'b1;
      wait_n(3);
      chk(input_current_limit, 32'h0000_0002);
      sys_below_2v2 <= 1'b0;
      clamp <= 6'h05;
      wait_n(3);
      chk(input_current_limit, 32'h0000_0005);
      wr(`CCP_OFF_CTRL, 32'h0000_0043);
      wait_n(2);
      chk(input_current_limit, 32'h0000_003F);
      src_high_power_det <= 1'b1;
      @(posedge pclk);
      src_high_power_det <= 1'b0;
      @(posedge pclk);
      chk(orun, 32'h0000_0001);
      optimizer_code <= 6'h11;
      optimizer_done <= 1'b1;
      @(posedge pclk);
      optimizer_done <= 1'b0;
      wait_n(3);
      chk(input_current_limit, 32'h0000_0011);
      chk(orun, 32'h0000_0000);
      wr(`CCP_OFF_CTRL, 32'h0000_0041);
      wait_n(2);
      chk(input_current_limit, 32'h0000_0008);
   endtask
   task t_flags;
      sys_below_bat <= 1'b1;
      bat_below_sysmin <= 1'b1;
      input_over_current <= 1'b1;
      input_under_voltage <= 1'b1;
      sys_at_min_reg <= 1'b1;
      wait_n(3);
      chk(battery_switch, 32'h0000_0001);
      rd(`CCP_OFF_STATUS);
      chk(q & 32'h0000_0CE0, 32'h0000_0CE0);
      {sys_below_bat, bat_below_sysmin, input_over_current, input_under_voltage, sys_at_min_reg} <= 5'h00;
      bat_below_depletion <= 1'b1;
      wait_n(3);
      rd(`CCP_OFF_STATUS);
      chk(q & 32'h0000_0CE0, 32'h0000_0800);
      bat_below_depletion <= 1'b0;
   endtask
   task t_charge;
      external_current_clamp_pin_set_done <= 1'b1;
      charge_enable_n <= 1'b0;
      thermistor_fault <= 1'b1;
      wait_n(4);
      chk(charging_active, 32'h0000_0000);
      thermistor_fault <= 1'b0;
      wait_n(4);
      chk(charging_active, 32'h0000_0001);
      chk(status_pin_out, 32'h0000_0000);
      rd(`CCP_OFF_STATUS);
      chk((q >> 3) & 32'h3, 32'h0000_0002);
      chk((q >> 11) & 32'h1, 32'h0000_0000);
      bat_below_3v <= 1'b1;
      wait_n(2);
      chk(ccm, 32'h0000_0001);
      rd(`CCP_OFF_STATUS);
      chk((q >> 3) & 32'h3, 32'h0000_0001);
      bat_below_3v <= 1'b0;
      thermal_reg <= 1'b1;
      chg_current_below_term <= 1'b1;
      bat_above_recharge <= 1'b1;
      wait_n(4);
      chk(charging_active, 32'h0000_0001);
      chk(thr, 32'h0000_0001);
      thermal_reg <= 1'b0;
      repeat (10) if (host_event !== 1'b1) @(posedge pclk);
      chk(host_event, 32'h0000_0001);
      rd(`CCP_OFF_STATUS);
      chk((q >> 3) & 32'h3, 32'h0000_0003);
      chk(status_pin_out, 32'h0000_0001);
      bat_above_recharge <= 1'b0;
      wait_n(4);
      chk(charging_active, 32'h0000_0001);
      wait_n(300);
      rd(`CCP_OFF_STATUS);
      chk((q >> 8) & 32'h3, 32'h0000_0003);
      charge_enable_n <= 1'b1;
   endtask
   task t_boost;
      {bat_above_lowv, vin_below_bat_sleep, boost_request_pin, thermistor_boost_ok} <= 4'hF;
      wr(`CCP_OFF_CTRL, 32'h0000_0051);
      wait_n(12);
      chk(boost_enable, 32'h0000_0000);
      wait_n(20);
      chk(boost_enable, 32'h0000_0001);
      rd(`CCP_OFF_STATUS);
      chk(q & 32'h7, 32'h0000_0007);
      wr(`CCP_OFF_CTRL, 32'h0000_0071);
      rd(`CCP_OFF_CTRL);
      chk(q, 32'h0000_0051);
      boost_request_pin <= 1'b0;
      wait_n(4);
      chk(boost_enable, 32'h0000_0000);
      wr(`CCP_OFF_CTRL, 32'h0000_0361);
      wait_n(2);
      chk({ros, bsr, oe}, 32'h0000_0004);
      wr(`CCP_OFF_CTRL, 32'h0000_0361);
      wait_n(2);
      chk(bsr, 32'h0000_0001);
   endtask
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_vlim;
      t_limit;
      t_flags;
      t_charge;
      t_boost;
      end_sim;
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      bad_count = bad_count + 1;
      end_sim;
   end
endmodule // tb_top
